// ==== bench/ddl_dev_model.sv ====
`timescale 1ns/1ns
// Behavioural latch set of the dual converter, both bus variants
module ddl_dev_model (
    // Byte bus
    input wire        sel_n,
    input wire        wr_n,
    input wire        adr_hi,
    input wire        adr_lo,
    input wire [3:0]  nib_up,
    input wire [3:0]  nib_lo,
    input wire        upd_n,
    // Word bus
    input wire        fs_n,
    input wire        ss_n,
    input wire        wld_n,
    input wire        top,
    input wire [10:0] low
);
    // Input, converter and word latches
    reg [11:0] in_a, in_b, dac_a, dac_b, w_a, w_b;
    // Power-up contents undefined, so start from zero
    initial {in_a, in_b, dac_a, dac_b, w_a, w_b} = 72'h0;
    // Update pulses seen, so a bare update is visible at all
    integer upd_seen = 0;
    ////////////////////////////////////////////////////////////
    // Transparent while selected and strobed with update high; holds otherwise
    always @* begin
        if (!sel_n && !wr_n && upd_n) begin
            case ({adr_hi, adr_lo})
                2'h0: in_a[7:0] = {nib_up, nib_lo};
                2'h1: in_a[11:8] = nib_lo;
                2'h2: in_b[7:0] = {nib_up, nib_lo};
                default: in_b[11:8] = nib_lo;
            endcase
        end
    end
    // Update is level, asynchronous to the write strobe
    always @* begin
        if (!upd_n) begin
            dac_a = in_a;
            dac_b = in_b;
        end
    end
    always @(negedge upd_n) upd_seen = upd_seen + 1;
    // Switch controls of channel A: thermometer segments over a plain ladder
    wire [2:0]  seg_a    = {dac_a[11:10] == 2'h3, dac_a[11], dac_a[11:10] != 2'h0};
    wire [9:0]  ladder_a = dac_a[9:0];
    // Quarters steered by segments above the ladder code: unsigned fraction
    wire [11:0] level_a  = {{1'b0, seg_a[2]} + {1'b0, seg_a[1]} + {1'b0, seg_a[0]}, ladder_a};
    // Word latches take the bus only on the rising strobe
    always @(posedge wld_n) begin
        if (!fs_n) w_a <= {top, low};
        if (!ss_n) w_b <= {top, low};
    end
endmodule

// ==== bench/ddl_host_checker.sv ====
`timescale 1ns/1ns
// Watches the host pins for strobe framing and command timing
module ddl_host_checker (
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // User side
    input wire       cmd_valid,
    input wire [2:0] cmd_op,
    input wire       cmd_ready_ff,
    input wire       cmd_done_ff,
    // Device pins
    input wire       dev_select_n_ff,
    input wire       load_strobe_n_ff,
    input wire       update_strobe_n_ff,
    input wire       chan_first_select_n_ff,
    input wire       chan_second_select_n_ff,
    input wire       word_load_n_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Command taken this edge
    wire tk = cmd_valid && cmd_ready_ff;
    ////////////////////////////////////////////////////////////
    AST_SEL_FRAME: assert property (!load_strobe_n_ff |-> !dev_select_n_ff)
        else $error("write strobe low while device not selected");
    AST_SEL_SETUP: assert property ($fell(load_strobe_n_ff) |-> !$past(dev_select_n_ff))
        else $error("select not set up before write strobe");
    AST_UPD_ALONE: assert property (!update_strobe_n_ff |-> load_strobe_n_ff && dev_select_n_ff)
        else $error("update overlaps a write");
    AST_UPD_PULSE: assert property ($fell(update_strobe_n_ff) |=> update_strobe_n_ff)
        else $error("update strobe not one cycle");
    AST_WORD_SEL: assert property (!word_load_n_ff |-> !(chan_first_select_n_ff && chan_second_select_n_ff))
        else $error("word strobe low with no channel selected");
    AST_WORD_EDGE: assert property ($rose(word_load_n_ff) |->
        $stable({chan_first_select_n_ff, chan_second_select_n_ff}))
        else $error("channel select moved at latch edge");
    AST_TAKE: assert property (tk |=> !cmd_ready_ff && !cmd_done_ff)
        else $error("ready still high after take");
    AST_DONE_PULSE: assert property (cmd_done_ff |=> !cmd_done_ff)
        else $error("done longer than one cycle");
    AST_LAT_WORD: assert property (tk && cmd_op < 3'h3 |-> ##5 cmd_done_ff)
        else $error("word load latency wrong");
    AST_LAT_UPD: assert property (tk && cmd_op == 3'h3 |-> ##3 cmd_done_ff)
        else $error("update latency wrong");
    AST_LAT_BYTE: assert property (tk && cmd_op == 3'h4 |-> ##15 cmd_done_ff)
        else $error("byte load latency wrong");
endmodule
bind ddl_host ddl_host_checker ddl_host_checker_inst (.clk, .reset, .cmd_valid, .cmd_op,
    .cmd_ready_ff, .cmd_done_ff, .dev_select_n_ff, .load_strobe_n_ff, .update_strobe_n_ff,
    .chan_first_select_n_ff, .chan_second_select_n_ff, .word_load_n_ff);

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
// Self-checking bench for the dual converter host
module testbench;
    // Clock, reset and user port
    reg         clk, reset, cmd_valid;
    reg  [2:0]  cmd_op;
    reg  [11:0] cmd_word_a, cmd_word_b;
    // Pins between host and model
    wire        rdy, done, sel_n, wr_n, adr_hi, adr_lo, upd_n, fs_n, ss_n, wld_n, top;
    wire [3:0]  nib_up, nib_lo;
    wire [10:0] low;
    integer     n_errors, cmp_count;
    ddl_host ddl_host_inst (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_word_a(cmd_word_a), .cmd_word_b(cmd_word_b), .cmd_ready_ff(rdy), .cmd_done_ff(done),
        .dev_select_n_ff(sel_n), .load_strobe_n_ff(wr_n), .latch_addr_high_ff(adr_hi),
        .latch_addr_low_ff(adr_lo), .bus_upper_nibble_ff(nib_up), .bus_lower_nibble_ff(nib_lo),
        .update_strobe_n_ff(upd_n), .chan_first_select_n_ff(fs_n), .chan_second_select_n_ff(ss_n),
        .word_load_n_ff(wld_n), .word_top_bit_ff(top), .word_lower_bits_ff(low));
    ddl_dev_model ddl_dev_model_inst (.sel_n, .wr_n, .adr_hi, .adr_lo, .nib_up, .nib_lo, .upd_n,
        .fs_n, .ss_n, .wld_n, .top, .low);
    ////////////////////////////////////////////////////////////
    // Compare seen against expected; unknowns never match
    task chk(input [63:0] nm, input [63:0] got, input [63:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    // One command from a falling edge; returns at the done cycle
    task run(input [2:0] op, input [11:0] a, input [11:0] b, input [31:0] lat);
        integer n;
        begin
            cmd_op = op;
            cmd_word_a = a;
            cmd_word_b = b;
            cmd_valid = 1'b1;
            while (rdy !== 1'b1) @(negedge clk);
            @(negedge clk);
            cmd_valid = 1'b0;
            n = 1; // Edges from the take edge to the one that samples done
            while (done !== 1'b1 && n < 40) begin
                @(negedge clk);
                n = n + 1;
            end
            chk("latency", n, lat);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Idle pin levels after reset
    task t_reset;
        begin
            chk("ready", rdy, 1);
            chk("strobes", {sel_n, wr_n, upd_n, fs_n, ss_n, wld_n}, 6'h3F);
            chk("data", {nib_up, nib_lo, top, low}, 20'h00000);
        end
    endtask
    // Back-to-back word loads to A, B, then both
    task t_word;
        begin
            run(3'h0, 12'hFFF, 12'h123, 5);
            chk("word_a", {ddl_dev_model_inst.w_a, ddl_dev_model_inst.w_b}, 24'hFFF000);
            run(3'h1, 12'h456, 12'h800, 5);
            chk("word_b", {ddl_dev_model_inst.w_a, ddl_dev_model_inst.w_b}, 24'hFFF800);
            run(3'h2, 12'h001, 12'h7FE, 5);
            chk("word_ab", {ddl_dev_model_inst.w_a, ddl_dev_model_inst.w_b}, 24'h001001);
        end
    endtask
    // Four byte writes then a joint update; word latches untouched
    task t_byte;
        begin
            run(3'h4, 12'hA5C, 12'h3B7, 15);
            chk("input", {ddl_dev_model_inst.in_a, ddl_dev_model_inst.in_b}, 24'hA5C3B7);
            chk("dac", {ddl_dev_model_inst.dac_a, ddl_dev_model_inst.dac_b}, 24'hA5C3B7);
            chk("word", {ddl_dev_model_inst.w_a, ddl_dev_model_inst.w_b}, 24'h001001);
            chk("seg", ddl_dev_model_inst.seg_a, 3'h3);
            chk("ladder", ddl_dev_model_inst.ladder_a, 10'h25C);
            chk("level", ddl_dev_model_inst.level_a, 12'hA5C);
            chk("upd_cnt", ddl_dev_model_inst.upd_seen, 1);
        end
    endtask
    // Bare update keeps converter contents
    task t_upd;
        begin
            run(3'h3, 12'h000, 12'h000, 3);
            chk("dac_hold", {ddl_dev_model_inst.dac_a, ddl_dev_model_inst.dac_b}, 24'hA5C3B7);
            chk("upd_cnt", ddl_dev_model_inst.upd_seen, 2);
        end
    endtask
    // Verdict and end of run
    task complete_run;
        begin
            if (n_errors == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Main sequence
    initial begin
        {reset, cmd_valid, cmd_op, cmd_word_a, cmd_word_b} = {1'b1, 28'h0};
        n_errors = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        t_reset;
        t_word;
        t_byte;
        t_upd;
        complete_run;
    end
    // Watchdog, well past the expected run length
    initial begin
        #200000;
        n_errors = n_errors + 1;
        complete_run;
    end
endmodule

// ==== rtl/ddl_consts.vh ====
`ifndef DDL_CONSTS_VH
`define DDL_CONSTS_VH

// Latch address codes on the high/low address pair
`define DDL_ADDR_A_LOW      2'h0
`define DDL_ADDR_A_HIGH     2'h1
`define DDL_ADDR_B_LOW      2'h2
`define DDL_ADDR_B_HIGH     2'h3

// Command codes on the user port
`define DDL_CMD_LOAD_A      3'h0
`define DDL_CMD_LOAD_B      3'h1
`define DDL_CMD_LOAD_BOTH   3'h2
`define DDL_CMD_UPDATE      3'h3
`define DDL_CMD_LOAD_UPD    3'h4

// Word field positions
`define DDL_WORD_W          12
`define DDL_HIGH_MSB        11
`define DDL_HIGH_LSB        8
`define DDL_LOW_MSB         7
`define DDL_LOW_LSB         0

// Timing in ns, rounded up to clock cycles (one cycle is 100 ns)
`define DDL_CLK_NS          100
`define DDL_SETUP_NS        100
`define DDL_STROBE_NS       100
`define DDL_HOLD_NS         100
`define DDL_UPD_NS          100
`define DDL_CYC(ns)         (((ns) + `DDL_CLK_NS - 1) / `DDL_CLK_NS)
`define DDL_SETUP_CYC       `DDL_CYC(`DDL_SETUP_NS)
`define DDL_STROBE_CYC      `DDL_CYC(`DDL_STROBE_NS)
`define DDL_HOLD_CYC        `DDL_CYC(`DDL_HOLD_NS)
`define DDL_UPD_CYC         `DDL_CYC(`DDL_UPD_NS)

`endif

// ==== rtl/ddl_host.v ====
// Behaviour
// - Select low framing every byte-bus write
// - Write strobe low with select, address
// - High address line is code MSB
// - Low nibble lines carry bits 11:8 when high
// - First channel select low loads A
// - Second channel select low loads B
// - Word bus drives bits 11 to 0
// - Codes 00,01,10,11 pick A-low,A-high,B-low,B-high
// - Update pulsed low only once select is back high
`timescale 1ns/1ns
`include "ddl_consts.vh"
module ddl_host (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // User command port
    input  wire        cmd_valid,
    input  wire [2:0]  cmd_op,
    input  wire [11:0] cmd_word_a,
    input  wire [11:0] cmd_word_b,
    output reg         cmd_ready_ff,
    output reg         cmd_done_ff,
    // Byte-bus variant pins
    output reg         dev_select_n_ff,
    output reg         load_strobe_n_ff,
    output reg         latch_addr_high_ff,
    output reg         latch_addr_low_ff,
    output reg  [3:0]  bus_upper_nibble_ff,
    output reg  [3:0]  bus_lower_nibble_ff,
    output reg         update_strobe_n_ff,
    // Word-bus variant pins
    output reg         chan_first_select_n_ff,
    output reg         chan_second_select_n_ff,
    output reg         word_load_n_ff,
    output reg         word_top_bit_ff,
    output reg  [10:0] word_lower_bits_ff
);

    ////////////////////////////////////////////////////////////////////////
    // States
    localparam ST_IDLE   = 3'h0;   // Waiting for a command
    localparam ST_SETUP  = 3'h1;   // Select and data out, strobe high
    localparam ST_STROBE = 3'h2;   // Strobe low
    localparam ST_HOLD   = 3'h3;   // Strobe high, data held
    localparam ST_UPD    = 3'h4;   // Update strobe low
    localparam ST_FIN    = 3'h5;   // Report completion

    reg [2:0]  state_ff;       // Sequencer state
    reg [2:0]  nxt_state;
    reg [2:0]  op_ff;          // Command being run
    reg [2:0]  nxt_op;         // Command that the pins follow this edge
    reg [11:0] word_a_ff;      // Words captured at acceptance
    reg [11:0] word_b_ff;
    reg [11:0] nxt_word_a;     // Words that the pins follow this edge
    reg [11:0] nxt_word_b;
    reg [1:0]  step_ff;        // Byte write index, 0..3
    reg [1:0]  nxt_step;
    reg        t_load;         // Timer reload
    reg [3:0]  t_count;
    wire       t_done;

    // Phase counts, cut to the timer width on purpose; all are small
    localparam [31:0] SETUP_CYC  = `DDL_SETUP_CYC;
    localparam [31:0] STROBE_CYC = `DDL_STROBE_CYC;
    localparam [31:0] HOLD_CYC   = `DDL_HOLD_CYC;
    localparam [31:0] UPD_CYC    = `DDL_UPD_CYC;

    // Paces each phase so every pin meets its minimum width
    ddl_phase_timer u_timer (
        .clk     (clk),
        .reset   (reset),
        .load    (t_load),
        .count   (t_count),
        .done_ff (t_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte-bus write needs the four latches; word ops use one cycle
    function is_byte;
        input [2:0] op;
        begin
            is_byte = (op == `DDL_CMD_UPDATE) || (op == `DDL_CMD_LOAD_UPD);
        end
    endfunction

    // Nibble packing for byte writes: even step low byte, odd high nibble
    function [7:0] byte_of;
        input [1:0]  step;
        input [11:0] wa;
        input [11:0] wb;
        reg   [11:0] w;
        begin
            w = step[1] ? wb : wa;
            if (step[0])
                byte_of = {w[`DDL_LOW_MSB:4], w[`DDL_HIGH_MSB:`DDL_HIGH_LSB]};
            else
                byte_of = w[`DDL_LOW_MSB:`DDL_LOW_LSB];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always @* begin
        nxt_state  = state_ff;
        nxt_step   = step_ff;
        nxt_op     = op_ff;
        nxt_word_a = word_a_ff;
        nxt_word_b = word_b_ff;
        t_load     = 1'b0;
        t_count    = 4'h1;
        case (state_ff)
            ST_IDLE: begin
                // Taken only while ready shows, never in the cycle after reset
                if (cmd_valid && cmd_ready_ff) begin
                    nxt_step   = 2'h0;
                    nxt_op     = cmd_op;
                    nxt_word_a = cmd_word_a;
                    nxt_word_b = cmd_word_b;
                    if (cmd_op == `DDL_CMD_UPDATE) begin
                        nxt_state = ST_UPD;
                        t_count   = UPD_CYC[3:0];
                    end else begin
                        nxt_state = ST_SETUP;
                        t_count   = SETUP_CYC[3:0];
                    end
                    t_load = 1'b1;
                end
            end
            ST_SETUP: begin
                if (t_done) begin
                    nxt_state = ST_STROBE;
                    t_load    = 1'b1;
                    t_count   = STROBE_CYC[3:0];
                end
            end
            ST_STROBE: begin
                if (t_done) begin
                    nxt_state = ST_HOLD;
                    t_load    = 1'b1;
                    t_count   = HOLD_CYC[3:0];
                end
            end
            ST_HOLD: begin
                if (t_done) begin
                    t_load = 1'b1;
                    if (is_byte(op_ff) && step_ff != 2'h3) begin
                        nxt_step  = step_ff + 2'h1;
                        nxt_state = ST_SETUP;
                        t_count   = SETUP_CYC[3:0];
                    end else if (is_byte(op_ff)) begin
                        // Update only after select is back high, so no overlap
                        nxt_state = ST_UPD;
                        t_count   = UPD_CYC[3:0];
                    end else begin
                        nxt_state = ST_FIN;
                    end
                end
            end
            ST_UPD: begin
                if (t_done)
                    nxt_state = ST_FIN;
            end
            ST_FIN: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and pin registers; strobes and selects idle high at reset, address and data low
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff                <= ST_IDLE;
            step_ff                 <= 2'h0;
            op_ff                   <= 3'h0;
            word_a_ff               <= 12'h000;
            word_b_ff               <= 12'h000;
            cmd_ready_ff            <= 1'b0;
            cmd_done_ff             <= 1'b0;
            dev_select_n_ff         <= 1'b1;
            load_strobe_n_ff        <= 1'b1;
            latch_addr_high_ff      <= 1'b0;
            latch_addr_low_ff       <= 1'b0;
            bus_upper_nibble_ff     <= 4'h0;
            bus_lower_nibble_ff     <= 4'h0;
            update_strobe_n_ff      <= 1'b1;
            chan_first_select_n_ff  <= 1'b1;
            chan_second_select_n_ff <= 1'b1;
            word_load_n_ff          <= 1'b1;
            word_top_bit_ff         <= 1'b0;
            word_lower_bits_ff      <= 11'h000;
        end else begin
            state_ff     <= nxt_state;
            step_ff      <= nxt_step;
            cmd_done_ff  <= (state_ff == ST_FIN);
            cmd_ready_ff <= (nxt_state == ST_IDLE);
            // Capture the command once at acceptance
            op_ff     <= nxt_op;
            word_a_ff <= nxt_word_a;
            word_b_ff <= nxt_word_b;
            // Byte-bus side: select and address stand over the whole write.
            // Pins follow the command being taken, so a stale one never leaks out.
            if (is_byte(nxt_op) && (nxt_state == ST_SETUP || nxt_state == ST_STROBE ||
                                    nxt_state == ST_HOLD) && nxt_op != `DDL_CMD_UPDATE) begin
                dev_select_n_ff     <= 1'b0;
                latch_addr_high_ff  <= nxt_step[1];
                latch_addr_low_ff   <= nxt_step[0];
                {bus_upper_nibble_ff, bus_lower_nibble_ff} <= byte_of(nxt_step, nxt_word_a, nxt_word_b);
            end else begin
                dev_select_n_ff <= 1'b1;
            end
            load_strobe_n_ff <= ~(is_byte(nxt_op) && nxt_state == ST_STROBE);
            // Update pulse stands alone, never during a write
            update_strobe_n_ff <= ~(nxt_state == ST_UPD);
            // Word-bus side: selects stand over setup, strobe and hold
            if (!is_byte(nxt_op) && (nxt_state == ST_SETUP || nxt_state == ST_STROBE ||
                                     nxt_state == ST_HOLD)) begin
                chan_first_select_n_ff  <= ~(nxt_op == `DDL_CMD_LOAD_A ||
                                             nxt_op == `DDL_CMD_LOAD_BOTH);
                chan_second_select_n_ff <= ~(nxt_op == `DDL_CMD_LOAD_B ||
                                             nxt_op == `DDL_CMD_LOAD_BOTH);
                // Word B only for channel B alone; otherwise word A
                {word_top_bit_ff, word_lower_bits_ff} <=
                    (nxt_op == `DDL_CMD_LOAD_B) ? nxt_word_b : nxt_word_a;
            end else begin
                chan_first_select_n_ff  <= 1'b1;
                chan_second_select_n_ff <= 1'b1;
            end
            // Rising edge at strobe-to-hold latches the word; data still held
            word_load_n_ff <= ~(!is_byte(nxt_op) && nxt_state == ST_STROBE);
        end
    end

endmodule

// ==== rtl/ddl_phase_timer.v ====
`timescale 1ns/1ns
// Down counter that paces each phase of a bus cycle
module ddl_phase_timer (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Control
    input  wire       load,
    input  wire [3:0] count,
    // Status
    output reg        done_ff
);

    reg [3:0] cnt_ff;   // Cycles left in the phase

    ////////////////////////////////////////////////////////////////////////
    // Count down after a load; done is high once the count reaches one
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff  <= 4'h0;
            done_ff <= 1'b1;
        end else if (load) begin
            cnt_ff  <= count;
            done_ff <= (count <= 4'h1);
        end else if (cnt_ff != 4'h0) begin
            cnt_ff  <= cnt_ff - 4'h1;
            done_ff <= (cnt_ff <= 4'h2);
        end else begin
            done_ff <= 1'b1;
        end
    end

endmodule
